// >>> accel_system_control_regs_tb.sv
`timescale 1ns/1ps
module accel_system_control_regs_tb;
   logic i_core_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rd;
   logic i_reg_wr, i_reg_rd, o_soft_reset, o_run_active, o_asleep, o_sample_tick;
   logic i_activity = 1'b0;
   logic i_buffer_empty = 1'b0;
   logic [3:0] i_wake_event = 4'h0;
   logic [7:0] i_inactivity_timeout = 8'h00;
   logic [2:0] o_output_sample_rate;
   logic [1:0] o_power_scheme;
   logic [10:0] o_osr;
   logic o_low_noise_range, o_fast_read, o_self_check_en, o_buffer_hold;
   logic o_irq_polarity, o_irq_drive_type;
   int mismatches = 0;
   int num_checks = 0;
   int n;
   logic [23:0] rows [5] = '{24'h2a_fefe, 24'h2b_bf9f, 24'h2c_fffb, 24'h30_ff00, 24'h2a_0606};
   always #20 i_core_clk = ~i_core_clk;
   acr_sys_ctrl #(.P_BASE_CYCLES(4)) acr_sys_ctrl_i (.i_core_clk, .i_resetn, .i_reg_addr,
      .i_reg_wdata, .i_reg_wr, .i_reg_rd, .i_inactivity_timeout, .i_activity, .i_wake_event,
      .i_buffer_empty, .o_reg_rdata, .o_soft_reset, .o_run_active, .o_asleep, .o_sample_tick,
      .o_output_sample_rate, .o_power_scheme, .o_osr, .o_low_noise_range, .o_fast_read,
      .o_self_check_en, .o_buffer_hold, .o_irq_polarity, .o_irq_drive_type);
   acr_host_model acr_host_model_i (.i_core_clk, .i_reg_rdata(o_reg_rdata),
      .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata), .o_reg_wr(i_reg_wr),
      .o_reg_rd(i_reg_rd));
   task automatic chk(input string s, input logic [10:0] e, input logic [10:0] g);
      num_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
      end
   endtask : chk
   task automatic final_report();
      if (mismatches == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report
   task automatic wait_tick();
      n = 0;
      do
      begin
         @(negedge i_core_clk);
         n++;
      end while (o_sample_tick !== 1'b1 && n < 3000);
      if (n >= 3000)
      begin
         chk("tick_wait", 11'h001, 11'h000);
         final_report();
      end
   endtask : wait_tick
   initial
   begin
      repeat (4) @(negedge i_core_clk);
      i_resetn = 1'b1;
      repeat (3) @(negedge i_core_clk);
      for (int k = 0; k < 5; k++)
      begin
         acr_host_model_i.wr_reg(rows[k][23:16], rows[k][15:8]);
         acr_host_model_i.rd_reg(rows[k][23:16], rd);
         chk("reg_rdata", {3'h0, rows[k][7:0]}, {3'h0, rd});
      end
      chk("ctrl_bits", 11'h01f, {6'h00, o_low_noise_range, o_fast_read, o_self_check_en,
         o_irq_polarity, o_irq_drive_type});
      acr_host_model_i.wr_reg(acr_pkg::ADDR_SYS_CTRL_TWO, 8'h02);
      acr_host_model_i.set_ctrl_one(8'h19);
      wait_tick();
      wait_tick();
      chk("wake_period", 11'd32, 11'(n));
      chk("wake_rate", 11'h003, {8'h00, o_output_sample_rate});
      chk("wake_osr", 11'd16, o_osr);
      acr_host_model_i.set_ctrl_one(8'h18);
      acr_host_model_i.wr_reg(acr_pkg::ADDR_SYS_CTRL_TWO, 8'h0e);
      acr_host_model_i.wr_reg(acr_pkg::ADDR_IRQ_CTRL, 8'h88);
      acr_host_model_i.set_ctrl_one(8'h59);
      repeat (3) wait_tick();
      chk("sleep_period", 11'd256, 11'(n));
      chk("sleep_rate", 11'h005, {8'h00, o_output_sample_rate});
      chk("sleep_scheme", 11'h001, {9'h000, o_power_scheme});
      chk("sleep_osr", 11'd4, o_osr);
      chk("hold_set", 11'h001, {10'h000, o_buffer_hold});
      i_buffer_empty = 1'b1;
      @(negedge i_core_clk);
      i_buffer_empty = 1'b0;
      @(negedge i_core_clk);
      chk("hold_clear", 11'h000, {10'h000, o_buffer_hold});
      i_activity = 1'b1;
      i_wake_event = 4'h1;
      @(negedge i_core_clk);
      i_wake_event = 4'h0;
      @(negedge i_core_clk);
      chk("woken", 11'h000, {10'h000, o_asleep});
      chk("hold_wake", 11'h001, {10'h000, o_buffer_hold});
      i_activity = 1'b0;
      i_buffer_empty = 1'b1;
      @(negedge i_core_clk);
      i_buffer_empty = 1'b0;
      chk("resleep", 11'h001, {10'h000, o_asleep});
      chk("hold_set_wins", 11'h001, {10'h000, o_buffer_hold});
      acr_host_model_i.wr_reg(acr_pkg::ADDR_SYS_CTRL_TWO, 8'h02);
      repeat (300) @(negedge i_core_clk);
      chk("no_autosleep", 11'h000, {10'h000, o_asleep});
      acr_host_model_i.wr_reg(acr_pkg::ADDR_SYS_CTRL_TWO, 8'h40);
      acr_host_model_i.wr_reg(acr_pkg::ADDR_IRQ_CTRL, 8'hff);
      chk("booting", 11'h001, {10'h000, o_soft_reset});
      n = 0;
      while (o_soft_reset !== 1'b0 && n < 20)
      begin
         @(negedge i_core_clk);
         n++;
      end
      // two of the boot cycles have passed by the time the loop starts
      chk("boot_len", 11'(acr_pkg::BOOT_CYCLES - 2), 11'(n));
      for (int k = 0; k < 3; k++)
      begin
         acr_host_model_i.rd_reg(8'h2a + 8'(k), rd);
         chk("default", 11'h000, {3'h0, rd});
      end
      chk("standby", 11'h000, {10'h000, o_run_active});
      chk("ctrl_clear", 11'h000, {6'h00, o_low_noise_range, o_fast_read, o_self_check_en,
         o_irq_polarity, o_irq_drive_type});
      acr_host_model_i.set_ctrl_one(8'h01);
      wait_tick();
      wait_tick();
      chk("fast_period", 11'd4, 11'(n));
      chk("fast_osr", 11'h002, o_osr);
      @(negedge i_core_clk);
      i_resetn = 1'b0;
      repeat (2) @(negedge i_core_clk);
      i_resetn = 1'b1;
      chk("reset_run", 11'h000, {10'h000, o_run_active});
      chk("reset_osr", 11'h000, o_osr);
      repeat (3) @(negedge i_core_clk);
      acr_host_model_i.rd_reg(acr_pkg::ADDR_SYS_CTRL_ONE, rd);
      chk("reset_one", 11'h000, {3'h0, rd});
      final_report();
   end
endmodule : accel_system_control_regs_tb

// >>> acr_host_model.sv
`timescale 1ns/1ps
module acr_host_model (
   input wire logic i_core_clk,
   input wire logic [7:0] i_reg_rdata,
   output logic [7:0] o_reg_addr,
   output logic [7:0] o_reg_wdata,
   output logic o_reg_wr,
   output logic o_reg_rd
);
   logic [7:0] cur1 = 8'h00;
   initial
   begin
      o_reg_addr = 8'h00;
      o_reg_wdata = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
   end
   // released lines show the inverse so stale values never look valid
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(negedge i_core_clk);
      o_reg_wr = 1'b0;
      o_reg_addr = ~a;
      o_reg_wdata = ~d;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_core_clk);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(negedge i_core_clk);
      o_reg_rd = 1'b0;
      o_reg_addr = ~a;
      @(negedge i_core_clk);
      d = i_reg_rdata;
   endtask : rd_reg
   // system_control_one fields other than run are only written by this host while the run bit is clear
   task automatic set_ctrl_one(input logic [7:0] d);
      if (cur1[0])
         wr_reg(acr_pkg::ADDR_SYS_CTRL_ONE, cur1 & 8'hfe);
      wr_reg(acr_pkg::ADDR_SYS_CTRL_ONE, d & 8'hfe);
      if (d[0])
         wr_reg(acr_pkg::ADDR_SYS_CTRL_ONE, d);
      cur1 = d;
   endtask : set_ctrl_one
endmodule : acr_host_model

// >>> acr_pkg.sv
package acr_pkg;
   // register map
   localparam logic [7:0] ADDR_SYS_CTRL_ONE = 8'h2a;
   localparam logic [7:0] ADDR_SYS_CTRL_TWO = 8'h2b;
   localparam logic [7:0] ADDR_IRQ_CTRL = 8'h2c;
   localparam logic [7:0] SYS_CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] SYS_CTRL_TWO_RST = 8'h00;
   localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
   // system_control_one fields
   localparam int SLEEP_RATE_POS = 6;
   localparam int OUT_RATE_POS = 3;
   localparam int LOW_NOISE_POS = 2;
   localparam int FAST_READ_POS = 1;
   localparam int RUN_POS = 0;
   // system_control_two fields
   localparam int SELF_CHECK_POS = 7;
   localparam int SOFT_RST_POS = 6;
   localparam int SLEEP_SCHEME_POS = 3;
   localparam int AUTOSLEEP_POS = 2;
   localparam int WAKE_SCHEME_POS = 0;
   // bit 5 reserved, bit 6 self-clearing: neither is stored
   localparam logic [7:0] SYS_CTRL_TWO_WMASK = 8'h9f;
   // interrupt_control fields, bit 2 reserved
   localparam int BUF_GATE_POS = 7;
   localparam int WAKE_EN_POS = 3;
   localparam int IRQ_POL_POS = 1;
   localparam int IRQ_DRIVE_POS = 0;
   localparam logic [7:0] IRQ_CTRL_WMASK = 8'hfb;
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int BASE_PERIOD_NS = 1250000;
   localparam int BASE_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int BOOT_TIME_NS = 160;
   localparam int BOOT_CYCLES = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_NOISE_LIMIT_G = 4;
   // inactivity step in base periods: 320 ms normally, 640 ms at slowest rate
   localparam int INACT_STEP_LOG2 = 8;
   localparam int INACT_STEP_SLOW_LOG2 = 9;
   localparam logic [2:0] RATE_SLOWEST = 3'h7;
   // sample period as log2 of base periods, by rate code 800 Hz .. 1.56 Hz
   localparam logic [0:7][3:0] PERIOD_LOG2 = {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9};
   // averaging depth log2, by power scheme then rate code
   localparam logic [0:3][0:7][3:0] OSR_LOG2 = {
      {4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h4, 4'h5, 4'h7},
      {4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h5},
      {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'ha},
      {4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h4}};
   typedef enum logic [1:0] {
      SCHEME_NORMAL,
      SCHEME_LOW_NOISE_LOW_POWER,
      SCHEME_HIGH_RES,
      SCHEME_LOW_POWER
   } acr_scheme_t;
   typedef enum logic [1:0] {
      MODE_STANDBY,
      MODE_WAKE,
      MODE_SLEEP,
      MODE_BOOT
   } acr_mode_t;
endpackage : acr_pkg

// >>> acr_rate_timer.sv
`timescale 1ns/1ps
module acr_rate_timer #(
   parameter int P_BASE_CYCLES = acr_pkg::BASE_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_run,
   input wire logic [2:0] i_rate,
   input wire logic [1:0] i_scheme,
   output logic o_base_tick,
   output logic o_sample_tick,
   output logic [2:0] o_rate,
   output logic [1:0] o_scheme,
   output logic [10:0] o_osr
);
   typedef struct packed {
      logic [23:0] base_cnt;
      logic [9:0] per_cnt;
      logic loaded;
      logic base_tick;
      logic sample_tick;
      logic [2:0] rate;
      logic [1:0] scheme;
      logic [10:0] osr;
   } acr_timer_st_t;

   acr_timer_st_t st_r;
   acr_timer_st_t st_nxt;
   logic [9:0] per_last;

   assign per_last = 10'((11'h001 << acr_pkg::PERIOD_LOG2[st_r.rate]) - 11'h001);

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.base_tick = 1'b0;
      st_nxt.sample_tick = 1'b0;
      if (!i_run)
      begin
         st_nxt.base_cnt = '0;
         st_nxt.per_cnt = '0;
         st_nxt.loaded = 1'b0;
      end
      else if (!st_r.loaded || (st_r.base_cnt == 24'(P_BASE_CYCLES - 1) && st_r.per_cnt == per_last))
      begin
         // settings are taken only at a period boundary
         st_nxt.loaded = 1'b1;
         st_nxt.base_cnt = '0;
         st_nxt.per_cnt = '0;
         st_nxt.base_tick = st_r.loaded;
         st_nxt.sample_tick = st_r.loaded;
         st_nxt.rate = i_rate;
         st_nxt.scheme = i_scheme;
         st_nxt.osr = 11'h001 << acr_pkg::OSR_LOG2[i_scheme][i_rate];
      end
      else if (st_r.base_cnt == 24'(P_BASE_CYCLES - 1))
      begin
         st_nxt.base_cnt = '0;
         st_nxt.per_cnt = st_r.per_cnt + 10'h001;
         st_nxt.base_tick = 1'b1;
      end
      else
      begin
         st_nxt.base_cnt = st_r.base_cnt + 24'h00_0001;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign o_base_tick = st_r.base_tick;
   assign o_sample_tick = st_r.sample_tick;
   assign o_rate = st_r.rate;
   assign o_scheme = st_r.scheme;
   assign o_osr = st_r.osr;
endmodule : acr_rate_timer

// >>> acr_sys_ctrl.sv
`timescale 1ns/1ps
module acr_sys_ctrl #(
   parameter int P_BASE_CYCLES = acr_pkg::BASE_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_inactivity_timeout,
   input wire logic i_activity,
   input wire logic [3:0] i_wake_event,
   input wire logic i_buffer_empty,
   output logic [7:0] o_reg_rdata,
   output logic o_soft_reset,
   output logic o_run_active,
   output logic o_asleep,
   output logic o_sample_tick,
   output logic [2:0] o_output_sample_rate,
   output logic [1:0] o_power_scheme,
   output logic [10:0] o_osr,
   output logic o_low_noise_range,
   output logic o_fast_read,
   output logic o_self_check_en,
   output logic o_buffer_hold,
   output logic o_irq_polarity,
   output logic o_irq_drive_type
);
   typedef struct packed {
      logic [7:0] ctrl_one;
      logic [7:0] ctrl_two;
      logic [7:0] irq_ctrl;
      acr_pkg::acr_mode_t mode;
      logic [2:0] boot_cnt;
      logic [16:0] inact_cnt;
      logic [7:0] rdata;
      logic hold;
      logic booting;
      logic asleep;
   } acr_ctrl_st_t;

   acr_ctrl_st_t st_r;
   acr_ctrl_st_t st_nxt;
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic base_tick;
   logic [2:0] want_rate;
   logic [1:0] want_scheme;
   logic [16:0] inact_limit;
   logic wr_one;
   logic wr_two;
   logic wr_irq;
   logic [2:0] period_rate;
   logic [1:0] period_scheme;

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst_sync_r <= 2'h0;
      end
      else
      begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   always_comb
   begin
      if (st_r.mode == acr_pkg::MODE_SLEEP)
      begin
         // sleep rates are the four slowest rate codes
         want_rate = {1'b1, st_r.ctrl_one[acr_pkg::SLEEP_RATE_POS +: 2]};
         want_scheme = st_r.ctrl_two[acr_pkg::SLEEP_SCHEME_POS +: 2];
      end
      else
      begin
         want_rate = st_r.ctrl_one[acr_pkg::OUT_RATE_POS +: 3];
         want_scheme = st_r.ctrl_two[acr_pkg::WAKE_SCHEME_POS +: 2];
      end
   end

   // timeout counts 320 ms steps, 640 ms at the slowest rate
   assign inact_limit = (period_rate == acr_pkg::RATE_SLOWEST) ?
      17'({9'h000, i_inactivity_timeout} << acr_pkg::INACT_STEP_SLOW_LOG2) :
      17'({9'h000, i_inactivity_timeout} << acr_pkg::INACT_STEP_LOG2);

   assign wr_one = i_reg_wr && i_reg_addr == acr_pkg::ADDR_SYS_CTRL_ONE;
   assign wr_two = i_reg_wr && i_reg_addr == acr_pkg::ADDR_SYS_CTRL_TWO;
   assign wr_irq = i_reg_wr && i_reg_addr == acr_pkg::ADDR_IRQ_CTRL;

   always_comb
   begin
      st_nxt = st_r;
      // read data is registered; unmapped addresses read zero
      if (i_reg_rd)
      begin
         unique case (i_reg_addr)
            acr_pkg::ADDR_SYS_CTRL_ONE: st_nxt.rdata = st_r.ctrl_one;
            acr_pkg::ADDR_SYS_CTRL_TWO: st_nxt.rdata = st_r.ctrl_two;
            acr_pkg::ADDR_IRQ_CTRL: st_nxt.rdata = st_r.irq_ctrl;
            default: st_nxt.rdata = 8'h00;
         endcase
      end
      if (st_r.mode != acr_pkg::MODE_BOOT)
      begin
         // no guard on run state; host must stand by first
         if (wr_one)
         begin
            st_nxt.ctrl_one = i_reg_wdata;
         end
         if (wr_two)
         begin
            st_nxt.ctrl_two = i_reg_wdata & acr_pkg::SYS_CTRL_TWO_WMASK;
         end
         if (wr_irq)
         begin
            st_nxt.irq_ctrl = i_reg_wdata & acr_pkg::IRQ_CTRL_WMASK;
         end
      end

      unique case (st_r.mode)
         acr_pkg::MODE_BOOT:
         begin
            // serial side held in reset until boot ends
            if (st_r.boot_cnt == 3'h0)
            begin
               st_nxt.mode = acr_pkg::MODE_STANDBY;
            end
            else
            begin
               st_nxt.boot_cnt = st_r.boot_cnt - 3'h1;
            end
         end
         acr_pkg::MODE_STANDBY:
         begin
            st_nxt.inact_cnt = '0;
            if (st_nxt.ctrl_one[acr_pkg::RUN_POS])
            begin
               st_nxt.mode = acr_pkg::MODE_WAKE;
            end
         end
         acr_pkg::MODE_WAKE:
         begin
            if (!st_nxt.ctrl_one[acr_pkg::RUN_POS])
            begin
               st_nxt.mode = acr_pkg::MODE_STANDBY;
            end
            else if (!st_r.ctrl_two[acr_pkg::AUTOSLEEP_POS] || i_activity)
            begin
               st_nxt.inact_cnt = '0;
            end
            else if (st_r.inact_cnt >= inact_limit)
            begin
               st_nxt.mode = acr_pkg::MODE_SLEEP;
               st_nxt.inact_cnt = '0;
               st_nxt.hold = st_r.hold || st_r.irq_ctrl[acr_pkg::BUF_GATE_POS];
            end
            else if (base_tick)
            begin
               st_nxt.inact_cnt = st_r.inact_cnt + 17'h0_0001;
            end
         end
         acr_pkg::MODE_SLEEP:
         begin
            if (!st_nxt.ctrl_one[acr_pkg::RUN_POS])
            begin
               st_nxt.mode = acr_pkg::MODE_STANDBY;
            end
            else if (!st_r.ctrl_two[acr_pkg::AUTOSLEEP_POS] ||
               (i_wake_event & st_r.irq_ctrl[acr_pkg::WAKE_EN_POS +: 4]) != 4'h0)
            begin
               st_nxt.mode = acr_pkg::MODE_WAKE;
               st_nxt.hold = st_r.hold || st_r.irq_ctrl[acr_pkg::BUF_GATE_POS];
            end
         end
      endcase

      // a gated wake/sleep transition in the same cycle as the emptying wins
      if (i_buffer_empty && !(st_r.irq_ctrl[acr_pkg::BUF_GATE_POS] &&
         (st_r.mode == acr_pkg::MODE_WAKE || st_r.mode == acr_pkg::MODE_SLEEP) &&
         (st_nxt.mode == acr_pkg::MODE_WAKE || st_nxt.mode == acr_pkg::MODE_SLEEP) &&
         st_nxt.mode != st_r.mode))
      begin
         st_nxt.hold = 1'b0;
      end

      // soft reset overrides every register and mode update except read data, from any mode other than boot
      if (wr_two && i_reg_wdata[acr_pkg::SOFT_RST_POS] && st_r.mode != acr_pkg::MODE_BOOT)
      begin
         st_nxt.ctrl_one = acr_pkg::SYS_CTRL_ONE_RST;
         st_nxt.ctrl_two = acr_pkg::SYS_CTRL_TWO_RST;
         st_nxt.irq_ctrl = acr_pkg::IRQ_CTRL_RST;
         st_nxt.mode = acr_pkg::MODE_BOOT;
         st_nxt.boot_cnt = 3'(acr_pkg::BOOT_CYCLES - 1);
         st_nxt.inact_cnt = '0;
         st_nxt.hold = 1'b0;
      end
      // decoded ahead of the flop so both outputs leave straight from a register
      st_nxt.booting = st_nxt.mode == acr_pkg::MODE_BOOT;
      st_nxt.asleep = st_nxt.mode == acr_pkg::MODE_SLEEP;
   end

   always_ff @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   acr_rate_timer #(
      .P_BASE_CYCLES(P_BASE_CYCLES)
   ) u_rate_timer (
      .i_core_clk(i_core_clk),
      .i_rst_n(rst_n),
      .i_run(st_r.mode == acr_pkg::MODE_WAKE || st_r.mode == acr_pkg::MODE_SLEEP),
      .i_rate(want_rate),
      .i_scheme(want_scheme),
      .o_base_tick(base_tick),
      .o_sample_tick(o_sample_tick),
      .o_rate(period_rate),
      .o_scheme(period_scheme),
      .o_osr(o_osr)
   );

   assign o_output_sample_rate = period_rate;
   assign o_power_scheme = period_scheme;
   assign o_reg_rdata = st_r.rdata;
   assign o_soft_reset = st_r.booting;
   assign o_run_active = st_r.ctrl_one[acr_pkg::RUN_POS];
   assign o_asleep = st_r.asleep;
   // downstream clamps to LOW_NOISE_LIMIT_G when set
   assign o_low_noise_range = st_r.ctrl_one[acr_pkg::LOW_NOISE_POS];
   // steers pointer and buffer reads to one byte per axis
   assign o_fast_read = st_r.ctrl_one[acr_pkg::FAST_READ_POS];
   assign o_self_check_en = st_r.ctrl_two[acr_pkg::SELF_CHECK_POS];
   assign o_buffer_hold = st_r.hold;
   assign o_irq_polarity = st_r.irq_ctrl[acr_pkg::IRQ_POL_POS];
   assign o_irq_drive_type = st_r.irq_ctrl[acr_pkg::IRQ_DRIVE_POS];
endmodule : acr_sys_ctrl

// >>> acr_sys_ctrl_asserts.sv
`timescale 1ns/1ps
module acr_sys_ctrl_asserts (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_soft_reset,
   input wire logic o_run_active,
   input wire logic o_asleep,
   input wire logic o_sample_tick,
   input wire logic [2:0] o_output_sample_rate,
   input wire logic [10:0] o_osr,
   input wire logic o_low_noise_range,
   input wire logic o_fast_read,
   input wire logic o_self_check_en
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   // writes during boot are dropped, so they are kept out of every cause
   wire w1 = i_reg_wr && i_reg_addr == acr_pkg::ADDR_SYS_CTRL_ONE && !o_soft_reset;
   wire w2 = i_reg_wr && i_reg_addr == acr_pkg::ADDR_SYS_CTRL_TWO && !o_soft_reset;
   wire srq = w2 && i_reg_wdata[acr_pkg::SOFT_RST_POS];
   a_run_write: assert property (w1 |=> o_run_active == $past(i_reg_wdata[0]))
      else $error("run bit does not follow write");
   a_range_bits: assert property (w1 |=> {o_low_noise_range, o_fast_read} == $past(i_reg_wdata[2:1]))
      else $error("low noise or fast read bit wrong");
   a_self_check: assert property (w2 && !srq |=> o_self_check_en == $past(i_reg_wdata[7]))
      else $error("self check bit wrong");
   a_boot_len: assert property (srq |=> o_soft_reset [*4] ##1 !o_soft_reset)
      else $error("boot length wrong");
   a_boot_clear: assert property (srq |=> !o_run_active && !o_self_check_en && !o_asleep)
      else $error("state not cleared by soft reset");
   a_boot_cause: assert property ($rose(o_soft_reset) |-> $past(srq))
      else $error("boot without soft reset write");
   a_two_read: assert property (i_reg_rd && i_reg_addr == acr_pkg::ADDR_SYS_CTRL_TWO |=> o_reg_rdata[6:5] == 2'b00)
      else $error("reserved or reset bit reads one");
   a_irq_read: assert property (i_reg_rd && i_reg_addr == acr_pkg::ADDR_IRQ_CTRL |=> !o_reg_rdata[2])
      else $error("reserved interrupt bit reads one");
   a_fast_osr: assert property (o_sample_tick && o_output_sample_rate == 3'h0 |-> o_osr == 11'h002)
      else $error("averaging depth at top rate wrong");
endmodule : acr_sys_ctrl_asserts
bind acr_sys_ctrl acr_sys_ctrl_asserts acr_sys_ctrl_asserts_i (.i_core_clk, .i_resetn, .i_reg_addr,
   .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_soft_reset, .o_run_active, .o_asleep,
   .o_sample_tick, .o_output_sample_rate, .o_osr, .o_low_noise_range, .o_fast_read,
   .o_self_check_en);
